// >>> src/lic_regs.sv
// node identity and general link control registers on the host port
// assumes host port inputs synchronous to i_clk; power reset = i_sys_rst
//
// Contract
// - after bus reset completes, node number loads from the phy unaided
// - bus number is 10-bit writable, forced to 0x3FF on bus reset
// - bus and node numbers form source address and filter incoming
// - node number writable by software but overwritten by phy assignment
// - identity shows read-only part code 15:8 and revision 7:0
// - control bit 22 holds byte-order strap sampled at power reset
// - strap 0 means big-endian host port, 1 means little-endian
// - in little-endian, data-swap pin selects data placement
// - control bit 21 set holds the transmitter in synchronous reset
// - control bit 20 set holds the receiver in synchronous reset
// - writing one to control bit 18 starts a phy-link interface reset
// - bit 18 clears itself once the interface reset is done
`include "lic_defs.svh"

module lic_regs
    import lic_pkg::*;
#(
    parameter logic [7:0] PART_CODE = `LIC_PART_DFLT, // arbitrary value
    parameter logic [7:0] REV_CODE  = `LIC_REV_DFLT   // arbitrary value
)
(
    input  wire logic                   i_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_ce,
    input  wire logic                   i_hp_sel,
    input  wire logic                   i_hp_wr,
    input  wire logic                   i_hp_rd,
    input  wire logic [`LIC_ADDR_W-1:0] i_hp_addr,
    input  wire logic [31:0]            i_hp_wdata,
    output      logic [31:0]            o_hp_rdata,
    output      logic                   o_hp_ack,
    input  wire logic                   i_av2_error_byte_order_pin,
    input  wire logic                   i_data_swap_pin,
    input  wire logic                   i_bus_reset,
    input  wire logic                   i_phy_node_valid,
    input  wire logic [5:0]             i_phy_node_num,
    input  wire logic [15:0]            i_rx_dest_addr,
    output      logic [15:0]            o_src_addr,
    output      logic                   o_rx_accept,
    output      logic                   o_byte_order_strap,
    output      logic                   o_transmitter_soft_reset,
    output      logic                   o_receiver_soft_reset,
    output      logic                   o_phy_link_if_reset
);

    lic_regs_reg_t st_reg;
    lic_regs_reg_t st_next;

    lic_pif_if     u_pif ();

    logic          hit_ident;
    logic          hit_ctrl;
    logic          wr_req;
    logic          rd_req;
    logic [31:0]   wr_word;
    logic [31:0]   ident_word;
    logic [31:0]   ctrl_word;
    logic [31:0]   rd_word;

    // interface reset sequencer
    lic_pif_seq u_pif_seq (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_ce       (i_ce),
        .pif        (u_pif.seq)
    );

    // word match above the byte lanes; offsets arrive as typed arguments
    function automatic logic word_hit(
        input logic [`LIC_ADDR_W-1:0] addr,
        input logic [`LIC_ADDR_W-1:0] ofs
    );
        return addr[`LIC_ADDR_W-1:`LIC_WORD_LSB]
               == ofs[`LIC_ADDR_W-1:`LIC_WORD_LSB];
    endfunction : word_hit

    // address decode: one aligned word per register
    always_comb
    begin
        hit_ident = word_hit(i_hp_addr, `LIC_OFS_IDENT);
        hit_ctrl  = word_hit(i_hp_addr, `LIC_OFS_CTRL);
        wr_req    = i_hp_sel && i_hp_wr;
        rd_req    = i_hp_sel && i_hp_rd && !i_hp_wr;
    end

    // host data is turned into register order before it lands
    assign wr_word = lic_swap(i_hp_wdata, st_reg.strap,
                              i_data_swap_pin);

    // identity word as seen by software
    always_comb
    begin
        ident_word = 32'h0000_0000;
        ident_word[`LIC_BUS_MSB:`LIC_BUS_LSB]   = st_reg.bus_number_field;
        ident_word[`LIC_NODE_MSB:`LIC_NODE_LSB] = st_reg.node_number_field;
        ident_word[`LIC_PART_MSB:`LIC_PART_LSB] = PART_CODE;
        ident_word[`LIC_REV_MSB:`LIC_REV_LSB]   = REV_CODE;
    end

    // control word; unlisted bits read as zero
    always_comb
    begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`LIC_CTL_STRAP]  = st_reg.strap;
        ctrl_word[`LIC_CTL_TXRST]  = st_reg.tx_rst;
        ctrl_word[`LIC_CTL_RXRST]  = st_reg.rx_rst;
        // shows only while the sequence runs, so rarely seen set
        ctrl_word[`LIC_CTL_PIFRST] = u_pif.busy;
    end

    // read mux; unmapped offsets return zero
    always_comb
    begin
        if (hit_ident)
            rd_word = ident_word;
        else if (hit_ctrl)
            rd_word = ctrl_word;
        else
            rd_word = 32'h0000_0000;
    end

    // a write of one to bit 18 while idle kicks off the sequence
    assign u_pif.start = i_ce && wr_req && hit_ctrl
                         && wr_word[`LIC_CTL_PIFRST]
                         && !u_pif.busy;

    // next state of the bank
    always_comb
    begin
        st_next       = st_reg;
        st_next.ack   = 1'b0;

        // software writes first, hardware updates below win
        if (wr_req && hit_ident)
        begin
            st_next.bus_number_field  = wr_word[`LIC_BUS_MSB:`LIC_BUS_LSB];
            st_next.node_number_field = wr_word[`LIC_NODE_MSB:`LIC_NODE_LSB];
            // part and revision codes have no storage
        end
        if (wr_req && hit_ctrl)
        begin
            st_next.tx_rst = wr_word[`LIC_CTL_TXRST];
            st_next.rx_rst = wr_word[`LIC_CTL_RXRST];
            // strap bit is not touched by writes
        end

        // bus reset beats a same-cycle software write
        if (i_bus_reset)
            st_next.bus_number_field = `LIC_BUS_ALL_ONES;

        // phy assignment beats a same-cycle software write
        if (i_phy_node_valid)
            st_next.node_number_field = i_phy_node_num;

        // answer every selected access one cycle later
        if (wr_req || rd_req)
            st_next.ack = 1'b1;
        if (rd_req)
            st_next.rdata = lic_swap(rd_word, st_reg.strap,
                                     i_data_swap_pin);

        // power reset: defaults, and the strap is caught from its pin
        if (i_sys_rst)
        begin
            st_next.bus_number_field  = `LIC_BUS_ALL_ONES;
            st_next.node_number_field = `LIC_NODE_RST;
            st_next.tx_rst  = 1'b0;
            st_next.rx_rst  = 1'b0;
            st_next.ack     = 1'b0;
            st_next.rdata   = 32'h0000_0000;
            st_next.strap   = i_av2_error_byte_order_pin;
        end
    end

    // single state register; reset acts even with the enable low
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || i_ce)
            st_reg <= st_next;
    end

    // outputs
    assign o_hp_rdata               = st_reg.rdata;
    assign o_hp_ack                 = st_reg.ack;
    assign o_byte_order_strap       = st_reg.strap;
    assign o_src_addr               = {st_reg.bus_number_field,
                                       st_reg.node_number_field};
    assign o_transmitter_soft_reset = st_reg.tx_rst;
    assign o_receiver_soft_reset    = st_reg.rx_rst;
    assign o_phy_link_if_reset      = u_pif.phy_rst;

    // incoming filter: own address or broadcast node on own bus
    assign o_rx_accept =
        (i_rx_dest_addr[15:6] == st_reg.bus_number_field)
        && ((i_rx_dest_addr[5:0] == st_reg.node_number_field)
            || (i_rx_dest_addr[5:0] == `LIC_NODE_BCAST));

    // ------------------------------------------------------------
    // checks; a low enable freezes state, so they pause with it
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst || !i_ce);

    // picks one bit out of a computed word, which cannot be sliced directly
    function automatic logic ctl_bit(
        input logic [31:0] w,
        input int          pos
    );
        return w[pos];
    endfunction : ctl_bit

    sequence s_wr_ident;
        i_hp_sel && i_hp_wr && hit_ident;
    endsequence

    sequence s_wr_ctrl;
        i_hp_sel && i_hp_wr && hit_ctrl;
    endsequence

    sequence s_rd_ident;
        i_hp_sel && i_hp_rd && !i_hp_wr && hit_ident;
    endsequence

    sequence s_rd_ctrl;
        i_hp_sel && i_hp_rd && !i_hp_wr && hit_ctrl;
    endsequence

    sequence s_pif_start;
        s_wr_ctrl ##0 wr_word[`LIC_CTL_PIFRST] && !u_pif.busy;
    endsequence

    AST_NODE_LOAD: assert property (
        i_phy_node_valid |=> o_src_addr[5:0] == $past(i_phy_node_num))
        else $error("node number not loaded from phy");

    AST_BUS_RESET: assert property (
        i_bus_reset |=> o_src_addr[15:6] == `LIC_BUS_ALL_ONES)
        else $error("bus number not forced to all ones");

    AST_RX_MATCH: assert property (
        (i_rx_dest_addr == o_src_addr) |-> o_rx_accept)
        else $error("own address rejected");

    AST_CODES_READ: assert property (
        s_rd_ident |=> o_hp_ack
            && (lic_swap(o_hp_rdata, o_byte_order_strap,
                         $past(i_data_swap_pin)) & 32'h0000_ffff)
               == {16'h0000, PART_CODE, REV_CODE})
        else $error("part or revision code wrong");

    AST_STRAP_HOLD: assert property (
        !$past(i_sys_rst) |-> $stable(o_byte_order_strap))
        else $error("byte order bit changed outside reset");

    AST_CTRL_WRITE: assert property (
        s_wr_ctrl |=> o_transmitter_soft_reset
            == ctl_bit(lic_swap($past(i_hp_wdata), o_byte_order_strap,
                                $past(i_data_swap_pin)), `LIC_CTL_TXRST))
        else $error("control write landed in wrong lane");

    AST_RST_READBACK: assert property (
        s_rd_ctrl ##1 !$past(i_hp_wr) |->
            {ctl_bit(lic_swap(o_hp_rdata, o_byte_order_strap,
                              $past(i_data_swap_pin)), `LIC_CTL_TXRST),
             ctl_bit(lic_swap(o_hp_rdata, o_byte_order_strap,
                              $past(i_data_swap_pin)), `LIC_CTL_RXRST)}
            == {o_transmitter_soft_reset, o_receiver_soft_reset})
        else $error("soft reset bits disagree with outputs");

    AST_PIF_START: assert property (
        s_pif_start |=> o_phy_link_if_reset [*2] ##1 u_pif.busy)
        else $error("interface reset did not start");

    AST_PIF_CLEAR: assert property (
        $rose(u_pif.busy) |-> ##[1:6] !u_pif.busy)
        else $error("interface reset bit did not clear");

    AST_BUS_WRITE: assert property (
        s_wr_ident ##0 !i_bus_reset |=>
            o_src_addr[15:6] == $past(wr_word[`LIC_BUS_MSB:`LIC_BUS_LSB]))
        else $error("bus number write did not land");

    AST_NODE_WRITE: assert property (
        s_wr_ident ##0 !i_phy_node_valid |=>
            o_src_addr[5:0] == $past(wr_word[`LIC_NODE_MSB:`LIC_NODE_LSB]))
        else $error("node number write did not land");

    AST_RX_OTHER_BUS: assert property (
        (i_rx_dest_addr[15:6] != o_src_addr[15:6]) |-> !o_rx_accept)
        else $error("packet for another bus accepted");

    // soft resets move only on a control write or a power reset, never on their own
    AST_TX_HOLD: assert property (
        !(wr_req && hit_ctrl) |=> $stable(o_transmitter_soft_reset))
        else $error("transmitter reset changed without a write");

    AST_RX_HOLD: assert property (
        !(wr_req && hit_ctrl) |=> $stable(o_receiver_soft_reset))
        else $error("receiver reset changed without a write");

    AST_PIF_READ_IDLE: assert property (
        s_rd_ctrl ##0 !u_pif.busy |=>
            !ctl_bit(lic_swap(o_hp_rdata, o_byte_order_strap,
                              $past(i_data_swap_pin)), `LIC_CTL_PIFRST))
        else $error("interface reset bit reads set while idle");

endmodule : lic_regs

// >>> src/lic_defs.svh
// constants for the link identity and control register bank
// assumes a 20 MHz system clock and a byte-addressed host port
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH

// host port address space
`define LIC_ADDR_W          12
`define LIC_OFS_IDENT       12'h000
`define LIC_OFS_CTRL        12'h004
`define LIC_WORD_LSB        2

// node identity field layout
`define LIC_BUS_W           10
`define LIC_NODE_W          6
`define LIC_BUS_MSB         31
`define LIC_BUS_LSB         22
`define LIC_NODE_MSB        21
`define LIC_NODE_LSB        16
`define LIC_PART_MSB        15
`define LIC_PART_LSB        8
`define LIC_REV_MSB         7
`define LIC_REV_LSB         0
`define LIC_BUS_ALL_ONES    10'h3ff
`define LIC_NODE_RST        6'h3f
`define LIC_NODE_BCAST      6'h3f

// arbitrary identity codes, not those of any real part
`define LIC_PART_DFLT       8'h5a
`define LIC_REV_DFLT        8'h0c

// general link control bit positions
`define LIC_CTL_STRAP       22
`define LIC_CTL_TXRST       21
`define LIC_CTL_RXRST       20
`define LIC_CTL_PIFRST      18

// interface reset timing
`define LIC_CLK_NS          50
`define LIC_PIF_HOLD_NS     100
`define LIC_PIF_RECOV_NS    100
`define LIC_PIF_CNT_W       4
`define LIC_PIF_HOLD_CYC    ((`LIC_PIF_HOLD_NS+`LIC_CLK_NS-1)/`LIC_CLK_NS)
`define LIC_PIF_RECOV_CYC   ((`LIC_PIF_RECOV_NS+`LIC_CLK_NS-1)/`LIC_CLK_NS)

`endif

// >>> src/lic_pkg.sv
// types and shared helpers of the link identity register bank
// assumes lic_defs.svh is on the include path
`include "lic_defs.svh"

package lic_pkg;

    // interface reset sequencer states
    typedef enum logic [1:0] {PIF_IDLE, PIF_HOLD, PIF_WAIT} lic_pif_st_t;

    typedef struct packed {
        lic_pif_st_t                st;
        logic [`LIC_PIF_CNT_W-1:0]  cnt;
    } lic_pif_reg_t;

    typedef struct packed {
        logic [`LIC_BUS_W-1:0]  bus_number_field;
        logic [`LIC_NODE_W-1:0] node_number_field;
        logic                   strap;
        logic                   tx_rst;
        logic                   rx_rst;
        logic                   ack;
        logic [31:0]            rdata;
    } lic_regs_reg_t;

    // host word order; both swaps are their own inverse
    function automatic logic [31:0] lic_swap(
        input logic [31:0] d,
        input logic        le,
        input logic        inv
    );
        logic [31:0] r;
        r = d;
        if (le && inv)
            r = {d[15:0], d[31:16]};
        else if (le)
            r = {d[7:0], d[15:8], d[23:16], d[31:24]};
        return r;
    endfunction : lic_swap

endpackage : lic_pkg

// >>> src/lic_pif_if.sv
// handshake between the register bank and the interface reset sequencer
// assumes both ends share one clock
interface lic_pif_if;
    logic start;
    logic busy;
    logic phy_rst;

    modport ctrl (output start, input busy, input phy_rst);
    modport seq  (input start, output busy, output phy_rst);
endinterface : lic_pif_if

// >>> src/lic_pif_seq.sv
// phy-link interface reset sequencer: hold phase, then recovery wait
// assumes start is a one-cycle pulse from the register bank
`include "lic_defs.svh"

module lic_pif_seq
    import lic_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_sys_rst,
    input  wire logic   i_ce,
    lic_pif_if.seq      pif
);

    lic_pif_reg_t st_reg;
    lic_pif_reg_t st_next;

    // hold the interface reset, then let the phy settle
    always_comb
    begin
        st_next = st_reg;
        unique case (st_reg.st)
            PIF_IDLE:
            begin
                if (pif.start)
                begin
                    st_next.st  = PIF_HOLD;
                    st_next.cnt = `LIC_PIF_CNT_W'(`LIC_PIF_HOLD_CYC - 1);
                end
            end
            PIF_HOLD:
            begin
                if (st_reg.cnt == '0)
                begin
                    st_next.st  = PIF_WAIT;
                    st_next.cnt = `LIC_PIF_CNT_W'(`LIC_PIF_RECOV_CYC - 1);
                end
                else
                    st_next.cnt = st_reg.cnt - 1'b1;
            end
            PIF_WAIT:
            begin
                // back to idle clears the control bit by itself
                if (st_reg.cnt == '0)
                    st_next.st = PIF_IDLE;
                else
                    st_next.cnt = st_reg.cnt - 1'b1;
            end
            default:
                st_next.st = PIF_IDLE;
        endcase
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            st_reg <= '{st: PIF_IDLE, cnt: '0};
        else if (i_ce)
            st_reg <= st_next;
    end

    assign pif.busy    = (st_reg.st != PIF_IDLE);
    assign pif.phy_rst = (st_reg.st == PIF_HOLD);

endmodule : lic_pif_seq

// >>> tb/lic_host_model.sv
// host processor model on the register bank's host port
// assumes the bench calls access() and the bank answers one cycle later
`include "lic_defs.svh"

module lic_host_model
(
    input  wire logic                   i_clk,
    output      logic                   o_sel,
    output      logic                   o_wr,
    output      logic                   o_rd,
    output      logic [`LIC_ADDR_W-1:0] o_addr,
    output      logic [31:0]            o_wdata,
    input  wire logic [31:0]            i_rdata,
    input  wire logic                   i_ack
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle port at time zero
    initial
    begin
        o_sel = 1'b0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = '0;
        o_wdata = '0;
    end

    // one access: present for one cycle, take ack and data in the next
    task automatic access(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic ack);
        @(negedge i_clk);
        o_sel = 1'b1;
        o_wr = wr;
        o_rd = ~wr;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk);
        q = i_rdata;
        ack = i_ack;
        o_sel = 1'b0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;  // released lines must not keep the old value
        o_wdata = ~d;
    endtask : access
endmodule : lic_host_model

// >>> tb/test_link_identity_and_control_regs.sv
// self-checking bench of the identity and control register bank
// assumes lic_regs with default codes, 50 ns clock, host model beside it
`include "lic_defs.svh"

`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module test_link_identity_and_control_regs;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, sys_rst, strap_pin, swap_pin, bus_rst, node_vld, ack, acc;
    logic sel, wr, rd_s;
    logic [11:0] addr;
    logic [31:0] wdata, rdata;
    logic [5:0]  node_num;
    logic [15:0] dst, src;
    logic        tx_o, rx_o, strap_o, pif_o;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 9;
    int m_bus, m_node, m_strap, m_tx, m_rx;

    lic_host_model i_lic_host_model (.i_clk(clk), .o_sel(sel), .o_wr(wr),
        .o_rd(rd_s), .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata),
        .i_ack(ack));

    lic_regs i_lic_regs (.i_clk(clk), .i_sys_rst(sys_rst), .i_ce(1'b1),
        .i_hp_sel(sel), .i_hp_wr(wr), .i_hp_rd(rd_s), .i_hp_addr(addr),
        .i_hp_wdata(wdata), .o_hp_rdata(rdata), .o_hp_ack(ack),
        .i_av2_error_byte_order_pin(strap_pin), .i_data_swap_pin(swap_pin),
        .i_bus_reset(bus_rst), .i_phy_node_valid(node_vld),
        .i_phy_node_num(node_num), .i_rx_dest_addr(dst), .o_src_addr(src),
        .o_rx_accept(acc), .o_byte_order_strap(strap_o),
        .o_transmitter_soft_reset(tx_o), .o_receiver_soft_reset(rx_o),
        .o_phy_link_if_reset(pif_o));

    // free-running 20 MHz clock
    always #25 clk = ~clk;

    // model: host word order seen through the latched strap
    function automatic logic [31:0] hsw(input logic [31:0] d);
        if (m_strap == 0)
            return d;
        if (swap_pin)
            return {d[15:0], d[31:16]};
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : hsw

    function automatic logic [31:0] exp_id();
        return {m_bus[9:0], m_node[5:0], `LIC_PART_DFLT, `LIC_REV_DFLT};
    endfunction : exp_id

    function automatic logic [31:0] exp_ctl();
        return {9'h0, m_strap[0], m_tx[0], m_rx[0], 20'h0};
    endfunction : exp_ctl

    task automatic test_done();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic ak;
        i_lic_host_model.access(1'b0, a, 32'h0000_0000, q, ak);
        `CHK(ak, 1'b1)
    endtask : rd

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        ak;
        i_lic_host_model.access(1'b1, a, d, q, ak);
        `CHK(ak, 1'b1)
    endtask : wr_reg

    // one full pass under a given strap and swap-pin setting
    task automatic run_mode(input int strap, input int swp);
        logic [31:0] q, v;
        logic        e;
        sys_rst = 1'b1;
        strap_pin = strap[0];
        swap_pin = swp[0];
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        m_bus = 'h3ff;
        m_node = 'h3f;
        m_strap = strap;
        m_tx = 0;
        m_rx = 0;
        strap_pin = ~strap_pin; // latched level must not follow the pin
        rd(`LIC_OFS_IDENT, q);
        `CHK(q, hsw(exp_id()))
        rd(`LIC_OFS_CTRL, q);
        `CHK(hsw(q) & 32'h0074_0000, exp_ctl())
        // software write: bus and node writable, codes ignored
        v = $random(seed);
        wr_reg(`LIC_OFS_IDENT, hsw(v));
        m_bus = v[31:22];
        m_node = v[21:16];
        rd(`LIC_OFS_IDENT, q);
        `CHK(q, hsw(exp_id()))
        `CHK(src, {m_bus[9:0], m_node[5:0]})
        // incoming filter: random, own, broadcast and near-miss addresses
        for (int k = 0; k < 8; k++)
        begin
            @(negedge clk);
            dst = $random(seed);
            if (k == 1)
                dst = {m_bus[9:0], m_node[5:0]};
            if (k == 2)
                dst = {m_bus[9:0], 6'h3f};
            if (k == 3)
                dst = {m_bus[9:0], m_node[5:0] ^ 6'h01};
            #1;
            e = (dst[15:6] == m_bus[9:0]) &&
                (dst[5:0] == m_node[5:0] || dst[5:0] == 6'h3f);
            `CHK(acc, e)
        end
        // bus reset, then phy hands over the new node number
        @(negedge clk);
        bus_rst = 1'b1;
        @(negedge clk);
        bus_rst = 1'b0;
        m_bus = 'h3ff;
        `CHK(src, {m_bus[9:0], m_node[5:0]})
        v = $random(seed);
        node_vld = 1'b1;
        node_num = v[5:0];
        @(negedge clk);
        node_vld = 1'b0;
        node_num = ~v[5:0];
        m_node = v[5:0];
        `CHK(src, {m_bus[9:0], m_node[5:0]})
        rd(`LIC_OFS_IDENT, q);
        `CHK(q, hsw(exp_id()))
        // soft resets in every combination, strap bit written inverted
        for (int k = 0; k < 4; k++)
        begin
            v = exp_ctl();
            v[22] = ~m_strap[0];
            v[21] = k[1];
            v[20] = k[0];
            wr_reg(`LIC_OFS_CTRL, hsw(v));
            m_tx = k[1];
            m_rx = k[0];
            `CHK(tx_o, m_tx[0])
            `CHK(rx_o, m_rx[0])
            `CHK(strap_o, m_strap[0])
            rd(`LIC_OFS_CTRL, q);
            `CHK(hsw(q) & 32'h0074_0000, exp_ctl())
        end
        // interface reset: phy reset held two cycles, then bit 18 reads clear
        v = exp_ctl() | 32'h0004_0000;
        wr_reg(`LIC_OFS_CTRL, hsw(v));
        `CHK(pif_o, 1'b1)
        @(negedge clk);
        `CHK(pif_o, 1'b1)
        @(negedge clk);
        `CHK(pif_o, 1'b0)
        repeat (3) @(negedge clk);
        rd(`LIC_OFS_CTRL, q);
        `CHK(hsw(q) & 32'h0074_0000, exp_ctl())
        // unmapped places: reads give zero, writes change nothing
        rd(12'h008, q);
        `CHK(q, 32'h0000_0000)
        wr_reg(12'h00c, $random(seed));
        rd(`LIC_OFS_IDENT, q);
        `CHK(q, hsw(exp_id()))
    endtask : run_mode

    // hang guard, well above the three passes
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_fail++;
            test_done();
        end
    end

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        strap_pin = 1'b0;
        swap_pin = 1'b0;
        bus_rst = 1'b0;
        node_vld = 1'b0;
        node_num = 6'h00;
        dst = 16'h0000;
        run_mode(0, 0);
        run_mode(1, 0);
        run_mode(1, 1);
        test_done();
    end
endmodule : test_link_identity_and_control_regs
